// ==== src/lfe_pkg.sv ====
// Shared constants and types for the LED sequencer flow/arithmetic executor.
// Assumes a single 200 MHz system clock and a byte-addressed Avalon-MM host.
package lfe_pkg;

  // Engine and program store geometry
  localparam int unsigned NUM_ENG = 3;
  localparam int unsigned PROG_WORDS = 96;
  localparam int unsigned PC_W = 7;

  // Instruction clock derived from the system clock
  localparam int unsigned SYS_CLK_HZ = 200_000_000;
  localparam int unsigned INSTR_CLK_HZ = 32_000;
  localparam int unsigned TICK_DIV = SYS_CLK_HZ / INSTR_CLK_HZ;

  // Timing in instruction-clock ticks
  localparam int unsigned INSTR_TICKS = 16;
  localparam int unsigned XPULSE_TICKS = 3;
  localparam int unsigned XLOW_TICKS = 2;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_PC0 = 8'h37;
  localparam logic [7:0] IDX_VAR_D = 8'h3c;
  localparam logic [7:0] IDX_VAR_D_ALT = 8'h42;
  localparam logic [7:0] IDX_START0 = 8'h4c;
  localparam logic [7:0] IDX_PROG_ADDR = 8'h50;
  localparam logic [7:0] IDX_PROG_DATA = 8'h51;
  localparam logic [7:0] IDX_STATUS = 8'h52;
  localparam logic [7:0] IDX_VARS0 = 8'h54;

  // Reset values
  localparam logic [15:0] PROG_RESET = 16'h0000;
  localparam logic [7:0] VAR_RESET = 8'h00;
  localparam logic [6:0] START_RESET = 7'h00;

  // Opcode field [15:12] ([15:13] for trigger) and the restart word
  localparam logic [15:0] WORD_RESTART = 16'h0000;
  localparam logic [3:0] OPC_JUMP = 4'h8;
  localparam logic [3:0] OPC_IMM = 4'h9;
  localparam logic [3:0] OPC_VARS = 4'ha;
  localparam logic [3:0] OPC_END = 4'hc;
  localparam logic [2:0] OPC_TRIG = 3'h7;

  // Field positions
  localparam int unsigned COND_LSB = 10;
  localparam int unsigned TGT_LSB = 10;
  localparam int unsigned OPSEL_LSB = 8;
  localparam int unsigned SKIP_LSB = 4;
  localparam int unsigned V1_LSB = 2;
  localparam int unsigned V2_LSB = 0;
  localparam int unsigned WAIT_ENG_LSB = 7;
  localparam int unsigned WAIT_EXT_BIT = 12;
  localparam int unsigned SEND_ENG_LSB = 1;
  localparam int unsigned SEND_EXT_BIT = 6;
  localparam int unsigned TRIG_EXT_IDX = 3;

  // Arithmetic operations and jump conditions
  localparam logic [1:0] AR_LOAD = 2'h0;
  localparam logic [1:0] AR_ADD = 2'h1;
  localparam logic [1:0] AR_SUB = 2'h2;
  localparam logic [1:0] CND_NE = 2'h0;
  localparam logic [1:0] CND_GE = 2'h1;
  localparam logic [1:0] CND_BELOW = 2'h2;
  localparam logic [1:0] CND_SAME = 2'h3;

  typedef enum logic [3:0] {
    ST_HALT = 4'b0001,
    ST_RUN = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_XSEND = 4'b1000
  } lfe_state_t;

  typedef struct packed {
    logic is_rst;
    logic is_end;
    logic is_trig;
    logic is_jump;
    logic is_imm;
    logic is_vars;
    logic [3:0] wait_mask;
    logic [3:0] send_mask;
    logic [1:0] cond;
    logic [1:0] tgt;
    logic [1:0] op;
    logic [1:0] v1;
    logic [1:0] v2;
    logic [4:0] skip;
    logic [7:0] imm;
  } lfe_instr_t;

endpackage

// ==== src/lfe_flow_exec.sv ====
// Three-engine executor for restart, end, trigger, skip and variable instructions.
// Assumes Avalon-MM host on sys_clk and an open-drain trigger line resolved outside.
// How it works
// [RL1] Restart loads the engine program counter from its start address.
// [RL2] After restart, execution resumes at the engine start address.
// [RL3] Restart, end and send take sixteen instruction ticks; end halts the engine.
// [RL4] Program words reset to zero, which decodes as restart.
// [RL5] Wait lasts at least sixteen ticks and stalls until all masked triggers arrive.
// [RL6] Triggers from engines are latched until a wait consumes them.
// [RL7] Outside parties hold the trigger line low two ticks or more.
// [RL8] Own external trigger drives the line low exactly three ticks.
// [RL9] Own external pulse is never counted as received.
// [RL10] Send external completes before an external wait begins.
// [RL11] Wait mask: bits 7,8,9 engines, bit 12 external; 10,11 unused.
// [RL12] Send mask: bits 1,2,3 engines, bit 6 external; several allowed.
// [RL13] Four skips: not-equal, greater-or-equal, below, same; false falls through.
// [RL14] Skip count is five bits; zero behaves like normal sequencing.
// [RL15] Operand selector: A, B, shared C, or register D.
// [RL16] Load overwrites A, B or C with an 8-bit immediate.
// [RL17] A and B are per engine; C is shared by all.
// [RL18] Add immediate or two operands, wrapping modulo 256.
// [RL19] Subtract immediate or operand 2 from operand 1, wrapping modulo 256.
// [RL20] Skip comparisons are unsigned 8-bit, operand 1 against operand 2.
`timescale 1ns/1ps
module lfe_flow_exec #(
  parameter int unsigned TICK_DIV = lfe_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Open-drain trigger line
  input wire logic trig_in,
  output logic trig_out,
  output logic trig_oe_n
);

  localparam int unsigned NE = lfe_pkg::NUM_ENG;
  localparam int unsigned DIV_W = (TICK_DIV < 2) ? 1 : $clog2(TICK_DIV);

  initial begin
    if (TICK_DIV < 2) begin
      $error("TICK_DIV must be at least 2");
    end
  end

  // Decode of one program word
  function automatic lfe_pkg::lfe_instr_t decode(input logic [15:0] w);
    lfe_pkg::lfe_instr_t r;
    r = '0;
    r.is_rst = (w == lfe_pkg::WORD_RESTART); // see [RL4]
    r.is_end = (w[15:12] == lfe_pkg::OPC_END);
    r.is_trig = (w[15:13] == lfe_pkg::OPC_TRIG);
    r.is_jump = (w[15:12] == lfe_pkg::OPC_JUMP);
    r.is_imm = (w[15:12] == lfe_pkg::OPC_IMM);
    r.is_vars = (w[15:12] == lfe_pkg::OPC_VARS);
    r.wait_mask = {w[lfe_pkg::WAIT_EXT_BIT], w[lfe_pkg::WAIT_ENG_LSB +: 3]}; // see [RL11]
    r.send_mask = {w[lfe_pkg::SEND_EXT_BIT], w[lfe_pkg::SEND_ENG_LSB +: 3]}; // see [RL12]
    r.cond = w[lfe_pkg::COND_LSB +: 2];
    r.tgt = w[lfe_pkg::TGT_LSB +: 2];
    r.op = w[lfe_pkg::OPSEL_LSB +: 2];
    r.skip = w[lfe_pkg::SKIP_LSB +: 5]; // see [RL14]
    r.v1 = w[lfe_pkg::V1_LSB +: 2];
    r.v2 = w[lfe_pkg::V2_LSB +: 2];
    r.imm = w[7:0];
    return r;
  endfunction

  // Operand selection
  function automatic logic [7:0] opnd(input logic [1:0] s, input logic [7:0] a, input logic [7:0] b,
                                      input logic [7:0] c, input logic [7:0] d);
    case (s)
      2'h0: return a; // see [RL15]
      2'h1: return b;
      2'h2: return c;
      default: return d;
    endcase
  endfunction

  // Arithmetic result, 8-bit wrap
  function automatic logic [7:0] arith(input logic [1:0] op, input logic [7:0] x, input logic [7:0] y);
    case (op)
      lfe_pkg::AR_ADD: return 8'(x + y); // see [RL18]
      lfe_pkg::AR_SUB: return 8'(x - y); // see [RL19]
      default: return y; // see [RL16]
    endcase
  endfunction

  // Unsigned skip condition
  function automatic logic cond_true(input logic [1:0] c, input logic [7:0] x, input logic [7:0] y);
    case (c)
      lfe_pkg::CND_NE: return x != y; // see [RL13]
      lfe_pkg::CND_GE: return x >= y; // see [RL20]
      lfe_pkg::CND_BELOW: return x < y; // see [RL20]
      default: return x == y;
    endcase
  endfunction

  // Forward step; running past the store wraps to word 0
  function automatic logic [6:0] step(input logic [6:0] pc, input logic [4:0] skip);
    logic [7:0] s;
    s = {1'b0, pc} + 8'h01 + {3'h0, skip}; // see [RL14]
    return (s >= 8'(lfe_pkg::PROG_WORDS)) ? 7'h00 : s[6:0];
  endfunction

  logic [DIV_W-1:0] div_q;
  logic tick_q;
  logic [15:0] prog_q [lfe_pkg::PROG_WORDS];
  logic [6:0] prog_addr_q;
  logic [6:0] pc_q [NE];
  logic [6:0] start_q [NE];
  logic [3:0] cnt_q [NE];
  lfe_pkg::lfe_state_t st_q [NE];
  logic [3:0] trig_q [NE];
  logic [7:0] var_a_q [NE];
  logic [7:0] var_b_q [NE];
  logic [7:0] var_c_q;
  logic [7:0] var_d_q;
  logic [1:0] xcnt_q;
  logic [1:0] rlow_q;
  logic rfired_q;
  logic ext_fire_q;
  logic wait_q;
  logic [31:0] rdata_q;

  lfe_pkg::lfe_instr_t ins [NE];
  logic [7:0] op1 [NE];
  logic [7:0] op2 [NE];
  logic [NE-1:0] exec;
  logic [NE-1:0] wdone;
  logic [NE-1:0] take;
  logic xstart;
  logic wr_en;
  logic ctrl_wr;
  logic [7:0] idx;

  assign idx = avs_address[9:2];
  assign wr_en = avs_write && !wait_q;
  assign ctrl_wr = wr_en && (idx == lfe_pkg::IDX_CTRL);

  // Per-engine decode and operand fetch
  generate
    for (genvar e = 0; e < NE; e++) begin : g_eng
      assign ins[e] = decode(prog_q[pc_q[e]]);
      assign op1[e] = opnd(ins[e].v1, var_a_q[e], var_b_q[e], var_c_q, var_d_q);
      assign op2[e] = opnd(ins[e].v2, var_a_q[e], var_b_q[e], var_c_q, var_d_q);
      assign exec[e] = tick_q && (st_q[e] == lfe_pkg::ST_RUN) && (cnt_q[e] == 4'(lfe_pkg::INSTR_TICKS - 1));
      assign wdone[e] = tick_q && (st_q[e] == lfe_pkg::ST_WAIT)
                        && ((trig_q[e] & ins[e].wait_mask) == ins[e].wait_mask); // see [RL5]
      assign take[e] = exec[e] && ins[e].is_jump && cond_true(ins[e].cond, op1[e], op2[e]);
    end
  endgenerate

  assign xstart = |(exec & {ins[2].is_trig && ins[2].send_mask[lfe_pkg::TRIG_EXT_IDX],
                            ins[1].is_trig && ins[1].send_mask[lfe_pkg::TRIG_EXT_IDX],
                            ins[0].is_trig && ins[0].send_mask[lfe_pkg::TRIG_EXT_IDX]});

  // Instruction clock divider
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == DIV_W'(TICK_DIV - 1));
      div_q <= (div_q == DIV_W'(TICK_DIV - 1)) ? '0 : div_q + 1'b1;
    end
  end

  // Bus handshake: one wait cycle, then the access completes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
    end
  end

  // Read data captured in the wait cycle, stands while waitrequest is low
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else if (avs_read && wait_q) begin
      rdata_q <= '0;
      for (int e = 0; e < NE; e++) begin
        if (idx == 8'(lfe_pkg::IDX_PC0 + e)) rdata_q <= {25'h0, pc_q[e]};
        if (idx == 8'(lfe_pkg::IDX_START0 + e)) rdata_q <= {25'h0, start_q[e]};
        if (idx == 8'(lfe_pkg::IDX_VARS0 + e)) rdata_q <= {8'h00, var_c_q, var_b_q[e], var_a_q[e]};
      end
      case (idx)
        lfe_pkg::IDX_CTRL, lfe_pkg::IDX_STATUS: begin
          for (int e = 0; e < NE; e++) begin
            rdata_q[e] <= (st_q[e] != lfe_pkg::ST_HALT);
            rdata_q[4 + e] <= (st_q[e] == lfe_pkg::ST_WAIT) || (st_q[e] == lfe_pkg::ST_XSEND);
            rdata_q[12 + 4 * e +: 4] <= trig_q[e];
          end
          rdata_q[8] <= !trig_oe_n;
        end
        lfe_pkg::IDX_VAR_D, lfe_pkg::IDX_VAR_D_ALT: rdata_q <= {24'h0, var_d_q};
        lfe_pkg::IDX_PROG_ADDR: rdata_q <= {25'h0, prog_addr_q};
        lfe_pkg::IDX_PROG_DATA: rdata_q <= (prog_addr_q < 7'(lfe_pkg::PROG_WORDS))
                                           ? {16'h0, prog_q[prog_addr_q]} : 32'h0;
        default: ;
      endcase
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // Program store and its pointer; data writes auto-increment
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < lfe_pkg::PROG_WORDS; i++) prog_q[i] <= lfe_pkg::PROG_RESET; // see [RL4]
      prog_addr_q <= '0;
    end else if (wr_en && idx == lfe_pkg::IDX_PROG_ADDR) begin
      prog_addr_q <= avs_writedata[6:0];
    end else if (wr_en && idx == lfe_pkg::IDX_PROG_DATA) begin
      if (prog_addr_q < 7'(lfe_pkg::PROG_WORDS)) prog_q[prog_addr_q] <= avs_writedata[15:0];
      prog_addr_q <= prog_addr_q + 7'h01;
    end
  end

  // Start addresses and variable D, written by software only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int e = 0; e < NE; e++) start_q[e] <= lfe_pkg::START_RESET;
      var_d_q <= lfe_pkg::VAR_RESET;
    end else if (wr_en) begin
      for (int e = 0; e < NE; e++) begin
        if (idx == 8'(lfe_pkg::IDX_START0 + e)) start_q[e] <= avs_writedata[6:0];
      end
      if (idx == lfe_pkg::IDX_VAR_D || idx == lfe_pkg::IDX_VAR_D_ALT) var_d_q <= avs_writedata[7:0];
    end
  end

  // Engine sequencing; a software PC write wins over the engine
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int e = 0; e < NE; e++) begin
        st_q[e] <= lfe_pkg::ST_HALT;
        pc_q[e] <= '0;
        cnt_q[e] <= '0;
      end
    end else begin
      for (int e = 0; e < NE; e++) begin
        case (st_q[e])
          lfe_pkg::ST_HALT: begin
            if (ctrl_wr && avs_writedata[e]) begin
              st_q[e] <= lfe_pkg::ST_RUN;
              cnt_q[e] <= '0;
            end
          end
          lfe_pkg::ST_RUN: begin
            if (exec[e]) begin
              cnt_q[e] <= '0; // see [RL3]
              if (ins[e].is_rst) begin
                pc_q[e] <= start_q[e]; // see [RL1] see [RL2]
              end else if (ins[e].is_end) begin
                st_q[e] <= lfe_pkg::ST_HALT; // see [RL3]
              end else if (ins[e].is_trig && ins[e].send_mask[3] && ins[e].wait_mask[3]) begin
                st_q[e] <= lfe_pkg::ST_XSEND; // see [RL10]
              end else if (ins[e].is_trig && (ins[e].wait_mask != 4'h0)) begin
                st_q[e] <= lfe_pkg::ST_WAIT; // see [RL5]
              end else if (take[e]) begin
                pc_q[e] <= step(pc_q[e], ins[e].skip); // see [RL13]
              end else begin
                pc_q[e] <= step(pc_q[e], 5'h00);
              end
            end else if (tick_q) begin
              cnt_q[e] <= cnt_q[e] + 4'h1;
            end
          end
          lfe_pkg::ST_WAIT: begin
            if (wdone[e]) begin
              st_q[e] <= lfe_pkg::ST_RUN;
              pc_q[e] <= step(pc_q[e], 5'h00);
            end
          end
          lfe_pkg::ST_XSEND: begin
            if (trig_oe_n) st_q[e] <= lfe_pkg::ST_WAIT; // see [RL10]
          end
          default: st_q[e] <= lfe_pkg::ST_HALT;
        endcase
        if (ctrl_wr && !avs_writedata[e]) st_q[e] <= lfe_pkg::ST_HALT;
        if (wr_en && idx == 8'(lfe_pkg::IDX_PC0 + e)) pc_q[e] <= avs_writedata[6:0];
      end
    end
  end

  // Trigger latches; a new arrival wins over the clear of a finishing wait
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int e = 0; e < NE; e++) trig_q[e] <= 4'h0;
    end else begin
      for (int e = 0; e < NE; e++) begin
        logic [3:0] set;
        set = {ext_fire_q, 3'h0};
        for (int s = 0; s < NE; s++) begin
          if (exec[s] && ins[s].is_trig && ins[s].send_mask[e]) set[s] = 1'b1; // see [RL6] see [RL12]
        end
        trig_q[e] <= (trig_q[e] & ~(wdone[e] ? ins[e].wait_mask : 4'h0)) | set; // see [RL6]
      end
    end
  end

  // Variables; on equal-cycle writes to C the higher engine wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int e = 0; e < NE; e++) begin
        var_a_q[e] <= lfe_pkg::VAR_RESET;
        var_b_q[e] <= lfe_pkg::VAR_RESET;
      end
      var_c_q <= lfe_pkg::VAR_RESET;
    end else begin
      for (int e = 0; e < NE; e++) begin
        logic [7:0] cur;
        logic [7:0] res;
        cur = opnd(ins[e].tgt, var_a_q[e], var_b_q[e], var_c_q, var_d_q);
        res = ins[e].is_imm ? arith(ins[e].op, cur, ins[e].imm) : arith(ins[e].op, op1[e], op2[e]);
        if (exec[e] && (ins[e].is_imm || ins[e].is_vars)) begin
          case (ins[e].tgt)
            2'h0: var_a_q[e] <= res; // see [RL17]
            2'h1: var_b_q[e] <= res;
            2'h2: var_c_q <= res; // see [RL17]
            default: ;
          endcase
        end
      end
    end
  end

  // External send: low for exactly three ticks from the sending tick
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_oe_n <= 1'b1;
      xcnt_q <= '0;
    end else if (xstart) begin
      trig_oe_n <= 1'b0; // see [RL8]
      xcnt_q <= '0;
    end else if (!trig_oe_n && tick_q) begin
      if (xcnt_q == 2'(lfe_pkg::XPULSE_TICKS - 1)) trig_oe_n <= 1'b1; // see [RL8]
      xcnt_q <= xcnt_q + 2'h1;
    end
  end

  // Line driven value is always low; only the enable moves
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) trig_out <= 1'b0;
    else trig_out <= 1'b0;
  end

  // External receive filter; own pulse blocks it until the line is high again
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rlow_q <= '0;
      rfired_q <= 1'b0;
      ext_fire_q <= 1'b0;
    end else begin
      ext_fire_q <= 1'b0;
      if (!trig_oe_n) begin
        rlow_q <= '0;
        rfired_q <= 1'b1; // see [RL9]
      end else if (trig_in) begin
        rlow_q <= '0;
        rfired_q <= 1'b0;
      end else if (tick_q && !rfired_q) begin
        if (rlow_q == 2'(lfe_pkg::XLOW_TICKS - 1)) begin
          ext_fire_q <= 1'b1; // see [RL7]
          rfired_q <= 1'b1;
        end
        rlow_q <= rlow_q + 2'h1;
      end
    end
  end

  // Checking helpers: ticks since engine 0 began its instruction, ticks of own pulse
  logic [5:0] since_q;
  logic [2:0] xlen_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      since_q <= '0;
      xlen_q <= '0;
    end else begin
      if (st_q[0] != lfe_pkg::ST_RUN || exec[0]) since_q <= '0;
      else if (tick_q && since_q != 6'h3f) since_q <= since_q + 6'h01;
      if (trig_oe_n) xlen_q <= '0;
      else if (tick_q) xlen_q <= xlen_q + 3'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  AST_RESTART_PC: assert property (exec[0] && ins[0].is_rst && !wr_en |=> pc_q[0] == $past(start_q[0])) // see [RL2]
    else $error("restart did not load the start address");
  AST_INSTR_LEN: assert property (exec[0] |-> since_q == 6'd15) // see [RL3]
    else $error("instruction did not last sixteen ticks");
  AST_END_HALTS: assert property (exec[0] && ins[0].is_end && !ctrl_wr |=> st_q[0] == lfe_pkg::ST_HALT) // see [RL3]
    else $error("end did not halt the engine");
  AST_WAIT_STALL: assert property (st_q[0] == lfe_pkg::ST_WAIT && !wdone[0] && !wr_en |=> $stable(pc_q[0])) // see [RL5]
    else $error("program counter moved during an unmet wait");
  // Counter reaches three on the same edge that releases the line
  AST_XPULSE_LEN: assert property ($rose(trig_oe_n) |-> xlen_q == 3'd3) // see [RL8]
    else $error("own trigger pulse was not three ticks");
  AST_SELF_MASK: assert property (!trig_oe_n |=> !ext_fire_q) // see [RL9]
    else $error("own pulse counted as received trigger");
  AST_SEND_FIRST: assert property (st_q[0] == lfe_pkg::ST_XSEND |-> !trig_oe_n || $past(!trig_oe_n)) // see [RL10]
    else $error("external wait began before send finished");
  AST_TRIG_HOLD: assert property (exec[1] && ins[1].is_trig && ins[1].send_mask[0] |=> trig_q[0][1]) // see [RL6]
    else $error("trigger from engine 2 not latched");
  AST_ADD_WRAP: assert property (exec[0] && ins[0].is_imm && ins[0].op == lfe_pkg::AR_ADD && ins[0].tgt == 2'h0
                                 |=> var_a_q[0] == 8'($past(var_a_q[0]) + $past(ins[0].imm))) // see [RL18]
    else $error("add immediate result wrong");
  AST_SKIP: assert property (take[0] && !wr_en |=> pc_q[0] == $past(step(pc_q[0], ins[0].skip))) // see [RL13]
    else $error("taken skip landed on wrong word");

  COV_RESTART: cover property (exec[0] && ins[0].is_rst);
  COV_WAIT_DONE: cover property (wdone[0] ##1 st_q[0] == lfe_pkg::ST_RUN);
  COV_EXT_RX: cover property (ext_fire_q);
  COV_SKIP: cover property (take[0] && ins[0].skip != 5'h00);

endmodule

// ==== verification/lfe_peer.sv ====
// Peer device on the shared open-drain trigger line.
// Assumes the bench resolves the line with a pull-up and hands it back here.
`timescale 1ns/1ps
module lfe_peer #(
  parameter int unsigned DIV = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Resolved line and bench command
  input wire logic line,
  input wire logic go,
  input wire logic [3:0] ticks,
  // Pull-down and measured pulse
  output logic pull,
  output logic [15:0] low_len
);
  logic [15:0] hold_q;
  logic [15:0] run_q;

  // Holds the line for whole ticks, never shorter than asked
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_q <= 16'h0000;
    end else if (go) begin
      hold_q <= 16'(ticks) * 16'(DIV);
    end else if (hold_q != 16'h0000) begin
      hold_q <= hold_q - 16'h0001;
    end
  end
  assign pull = (hold_q != 16'h0000);

  // Times low pulses made by the other side only, so own pulls never mix in
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 16'h0000;
      low_len <= 16'h0000;
    end else if (!line && !pull) begin
      run_q <= run_q + 16'h0001;
    end else if (run_q != 16'h0000) begin
      low_len <= run_q;
      run_q <= 16'h0000;
    end
  end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the flow/arithmetic executor and a trigger-line peer.
// Assumes TICK_DIV of 4, so one instruction lasts 64 system clocks.
`timescale 1ns/1ps
module tb;
  localparam int unsigned DIV = 4;
  logic sys_clk, arst_n, avs_read, avs_write, avs_waitrequest, trig_in, trig_out, trig_oe_n, go, pull;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] ticks;
  logic [15:0] low_len;
  int errors, n_checks;

  // Pull-up line: low while either party pulls
  assign trig_in = !(trig_oe_n === 1'b0 || pull);

  lfe_flow_exec #(.TICK_DIV(DIV)) i_lfe_flow_exec (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trig_in(trig_in), .trig_out(trig_out), .trig_oe_n(trig_oe_n));
  lfe_peer #(.DIV(DIV)) i_lfe_peer (.sys_clk(sys_clk), .arst_n(arst_n), .line(trig_in), .go(go), .ticks(ticks),
    .pull(pull), .low_len(low_len));

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One bus access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      final_report();
    end
  endtask

  task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(nm, q, exp);
  endtask

  task automatic prog(input logic [6:0] a, input logic [15:0] w[$]);
    bus(1'b1, lfe_pkg::IDX_PROG_ADDR, {25'h0, a});
    foreach (w[i]) bus(1'b1, lfe_pkg::IDX_PROG_DATA, {16'h0, w[i]});
  endtask

  // Polls until every engine has halted, bounded
  task automatic wait_halt();
    int n;
    n = 0;
    do begin
      bus(1'b0, lfe_pkg::IDX_STATUS, 32'h0);
      n++;
    end while (q[2:0] !== 3'b000 && n < 400);
    if (q[2:0] !== 3'b000) begin
      errors++;
      final_report();
    end
  endtask

  task automatic t_reset();
    rd("prog word", lfe_pkg::IDX_PROG_DATA, 32'h0);
    rd("unmapped", 8'h10, 32'h0);
    bus(1'b1, lfe_pkg::IDX_VAR_D_ALT, 32'h1);
    rd("var d alias", lfe_pkg::IDX_VAR_D, 32'h1);
  endtask

  // Wraps both ways, a false below, a zero skip and an unsigned compare against D
  task automatic t_arith();
    prog(7'h00, '{16'h90fa, 16'h910a, 16'h9403, 16'haa04, 16'h8811, 16'h9001, 16'h8c00, 16'h841b, 16'h9063,
      16'hc000});
    bus(1'b1, lfe_pkg::IDX_CTRL, 32'h1);
    wait_halt();
    rd("vars eng1", lfe_pkg::IDX_VARS0, 32'h00ff0301);
    rd("shared c", lfe_pkg::IDX_VARS0 + 8'h1, 32'h00ff0000);
    rd("end pc", lfe_pkg::IDX_PC0, 32'h9);
  endtask

  // Word 0x11 keeps its reset value, so it must act as restart
  task automatic t_restart();
    prog(7'h10, '{16'h9101});
    bus(1'b1, lfe_pkg::IDX_START0 + 8'h1, 32'h10);
    bus(1'b1, lfe_pkg::IDX_PC0 + 8'h1, 32'h10);
    bus(1'b1, lfe_pkg::IDX_CTRL, 32'h2);
    repeat (270) @(posedge sys_clk);
    bus(1'b1, lfe_pkg::IDX_CTRL, 32'h0);
    rd("eng2 vars", lfe_pkg::IDX_VARS0 + 8'h1, 32'h00ff0002);
    rd("eng2 pc", lfe_pkg::IDX_PC0 + 8'h1, 32'h10);
  endtask

  // Engine 3 triggers engine 1 and the line in one instruction
  task automatic t_trig();
    prog(7'h30, '{16'he200, 16'h9077, 16'hc000});
    prog(7'h38, '{16'he042, 16'hc000});
    bus(1'b1, lfe_pkg::IDX_PC0, 32'h30);
    bus(1'b1, lfe_pkg::IDX_PC0 + 8'h2, 32'h38);
    bus(1'b1, lfe_pkg::IDX_CTRL, 32'h5);
    wait_halt();
    rd("eng1 after wait", lfe_pkg::IDX_VARS0, 32'h00ff0377);
    chk("pulse len", {16'h0, low_len}, 32'(3 * DIV));
    chk("drive level", {31'h0, trig_out}, 32'h0);
    bus(1'b0, lfe_pkg::IDX_STATUS, 32'h0);
    chk("latches", q & 32'h00fff000, 32'h0);
  endtask

  // Send and wait external together; own pulse must not end the wait
  task automatic t_ext();
    prog(7'h40, '{16'hf040, 16'h9055, 16'hc000});
    bus(1'b1, lfe_pkg::IDX_PC0, 32'h40);
    bus(1'b1, lfe_pkg::IDX_CTRL, 32'h1);
    repeat (200) @(posedge sys_clk);
    bus(1'b0, lfe_pkg::IDX_STATUS, 32'h0);
    chk("still waiting", q & 32'h00000011, 32'h11);
    go <= 1'b1;
    ticks <= 4'h2;
    @(posedge sys_clk);
    go <= 1'b0;
    wait_halt();
    rd("eng1 after ext", lfe_pkg::IDX_VARS0, 32'h00ff0355);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    {arst_n, avs_read, avs_write, go} = 4'h0;
    avs_address = 10'h000;
    avs_writedata = 32'h0;
    ticks = 4'h0;
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_arith();
    t_restart();
    t_trig();
    t_ext();
    final_report();
  end
endmodule
